// ==== pkg/download_pkg.sv ====
// Shared constants and types for the command interpreter and program download path.
// Assumes one core clock domain and one parallel port clock domain.
package download_pkg;

  // ******************************************
  // Command codes (upper nibble of first byte) and short write mode (lower nibble of first byte)
  // ******************************************
  localparam logic [3:0] CMD_FREEZE = 4'h0;
  localparam logic [3:0] CMD_RUN = 4'h1;
  localparam logic [3:0] CMD_FAST_DOWNLOAD = 4'h6;
  localparam logic [3:0] CMD_VERSION = 4'h7;
  localparam logic [3:0] CMD_REG_WRITE = 4'hb;
  localparam logic [3:0] CMD_MEM_WRITE_FIRST = 4'he;
  localparam logic [3:0] CMD_MEM_WRITE_SECOND = 4'hf;
  localparam logic [3:0] SHORT_WRITE_MODE = 4'h4;

  // ******************************************
  // Header lengths in bytes, minus one
  // ******************************************
  localparam logic [2:0] HDR_LAST_SHORT = 3'h1;
  localparam logic [2:0] HDR_LAST_MEDIUM = 3'h3;
  localparam logic [2:0] HDR_LAST_LONG = 3'h5;

  // ******************************************
  // Registers
  // ******************************************
  localparam logic [7:0] AREA_SELECT_INDEX = 8'h6b;
  localparam logic [7:0] AREA_SELECT_ALIAS = 8'hed;
  localparam logic [19:0] AREA_SELECT_RESET = 20'h00000;
  localparam int AREA_FIELD_LSB = 16;

  // ******************************************
  // Word assembly and memory layout
  // ******************************************
  localparam logic [2:0] LAST_NIBBLE = 3'h4;
  localparam logic [1:0] LAST_LONG_BYTE = 2'h3;
  localparam logic [1:0] LAST_SHORT_BYTE = 2'h1;
  localparam int MEM_SELECT_BIT = 12;
  localparam int MEM_ADDR_WIDTH = 13;
  localparam int MEM_DEPTH = 8192;
  localparam logic [1:0] VERSION_WORDS = 2'h2;

  typedef struct packed {
    logic we;
    logic [MEM_ADDR_WIDTH-1:0] addr;
    logic [19:0] data;
  } mem_write_t;

  typedef struct packed {
    logic [15:0] major;
    logic [3:0] derivative;
    logic [3:0] letter;
    logic [7:0] digit;
  } version_t;

  typedef enum {ST_COMMAND, ST_MEM_WRITE, ST_PIO_DOWNLOAD} parse_state_t;

endpackage

// ==== hw/two_entry_buffer.sv ====
// Two-entry valid/ready buffer.
// Assumes both sides run on clock_in.
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  logic [WIDTH-1:0] slot [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] fill;
  logic push;
  logic pop;

  assign in_ready_out = (fill != 2'h2);
  assign out_valid_out = (fill != 2'h0);
  assign out_data_out = slot[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clock_in) begin
    if (push) begin
      slot[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== hw/program_data_memory.sv ====
// Storage for both data memories, one write port and one registered read port.
// Assumes write and read share clock_in.
`timescale 1ns/1ps
module program_data_memory (
  input wire logic clock_in,
  input wire download_pkg::mem_write_t write_in,
  input wire logic [download_pkg::MEM_ADDR_WIDTH-1:0] read_addr_in,
  output logic [19:0] read_data_out
);
  logic [19:0] cells [download_pkg::MEM_DEPTH];

  always_ff @(posedge clock_in) begin
    if (write_in.we) begin
      cells[write_in.addr] <= write_in.data;
    end
  end

  always_ff @(posedge clock_in) begin
    read_data_out <= cells[read_addr_in];
  end
endmodule

// ==== hw/download_cmd_interpreter.sv ====
// Command interpreter: program download, version query and program area select.
// Assumes a control front end delivering command bytes on clock_in, and a
// parallel port on its own clock that may stop between transfers.
// What this block does
// - Code 6 takes 12-bit count and 16-bit address, then data comes via parallel port.
// - Count means number of 20-bit words stored from the start address.
// - Parallel data is five nibbles per word, most significant nibble first.
// - Run command starts execution at the entry address given.
// - Code may instead be loaded with memory write commands after same preparation.
// - Code 7 with no arguments queues exactly two 16-bit words for reading.
// - First version word is the major number, one decimal digit per nibble.
// - Second word: derivative bits 15:12, letter code 11:8, digit 7:0.
// - Letter code plus 41 hex gives the ASCII version letter.
// - Register 6B switches four RAM areas between data and program use.
// - Bits 19,18 select first memory halves; bits 17,16 the second memory's.
// - Code B writes a 20-bit value into register 6B (or its alias ED); writes to any other index are dropped.
// - Codes E and F write count words from start address, E into the first memory and F into the second.
`timescale 1ns/1ps
module download_cmd_interpreter #(
  parameter download_pkg::version_t VERSION = '{16'h0001, 4'h0, 4'h1, 8'h02}
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic ctrl_start_in,
  input wire logic ctrl_valid_in,
  input wire logic [7:0] ctrl_byte_in,
  output logic [15:0] version_data_out,
  output logic version_valid_out,
  input wire logic version_ready_in,
  input wire logic pio_clock_in,
  input wire logic pio_valid_in,
  input wire logic [7:0] pio_byte_in,
  output logic pio_ready_out,
  input wire logic [download_pkg::MEM_ADDR_WIDTH-1:0] dsp_fetch_addr_in,
  output logic [19:0] dsp_fetch_data_out,
  output logic [19:0] program_ram_area_select_out,
  output logic [3:0] program_area_enable_out,
  output logic freeze_out,
  output logic run_pulse_out,
  output logic [15:0] run_address_out,
  output logic download_busy_out
);

  // ******************************************
  // Decode helpers
  // ******************************************
  function automatic logic [2:0] header_last(input logic [3:0] code);
    case (code)
      download_pkg::CMD_FAST_DOWNLOAD, download_pkg::CMD_REG_WRITE: header_last = download_pkg::HDR_LAST_MEDIUM;
      download_pkg::CMD_MEM_WRITE_FIRST, download_pkg::CMD_MEM_WRITE_SECOND: header_last = download_pkg::HDR_LAST_LONG;
      default: header_last = download_pkg::HDR_LAST_SHORT;
    endcase
  endfunction

  function automatic logic is_area_index(input logic [7:0] index);
    is_area_index = (index == download_pkg::AREA_SELECT_INDEX) || (index == download_pkg::AREA_SELECT_ALIAS);
  endfunction

  // ******************************************
  // Parallel port domain
  // ******************************************
  logic link_reset_meta;
  logic link_reset;
  logic req_toggle;
  logic [7:0] pio_hold;
  logic ack_toggle;
  logic ack_meta;
  logic ack_sync;

  always_ff @(posedge pio_clock_in) begin
    link_reset_meta <= reset_in;
    link_reset <= link_reset_meta;
  end

  always_ff @(posedge pio_clock_in) begin
    ack_meta <= ack_toggle;
    ack_sync <= ack_meta;
  end

  // Only one byte in flight; the host stalls until the core has used it
  assign pio_ready_out = (req_toggle == ack_sync);

  always_ff @(posedge pio_clock_in) begin
    if (link_reset) begin
      req_toggle <= 1'b0;
    end else if (pio_valid_in && pio_ready_out) begin
      req_toggle <= ~req_toggle;
    end
  end

  always_ff @(posedge pio_clock_in) begin
    if (link_reset) begin
      pio_hold <= 8'h00;
    end else if (pio_valid_in && pio_ready_out) begin
      pio_hold <= pio_byte_in;
    end
  end

  // ******************************************
  // Byte crossing into the core domain
  // ******************************************
  logic req_meta;
  logic req_sync;
  logic have_byte;
  logic half;
  logic [7:0] byte_reg;
  logic [3:0] nib;

  always_ff @(posedge clock_in) begin
    req_meta <= req_toggle;
    req_sync <= req_meta;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      have_byte <= 1'b0;
      half <= 1'b0;
      ack_toggle <= 1'b0;
      byte_reg <= 8'h00;
    end else if (!have_byte) begin
      if (req_sync != ack_toggle) begin
        have_byte <= 1'b1;
        half <= 1'b0;
        byte_reg <= pio_hold;
      end
    end else if (half) begin
      have_byte <= 1'b0;
      ack_toggle <= ~ack_toggle;
    end else begin
      half <= 1'b1;
    end
  end

  assign nib = half ? byte_reg[3:0] : byte_reg[7:4];

  // ******************************************
  // Command parsing
  // ******************************************
  download_pkg::parse_state_t state;
  logic [2:0] hdr_count;
  logic [3:0] cmd;
  logic [39:0] hdr;
  logic [47:0] full;
  logic [3:0] cmd_now;
  logic cmd_done;
  logic short_mode;
  logic mem_second;
  logic [15:0] words_left;
  logic [15:0] write_addr;
  logic [2:0] nib_count;
  logic [1:0] word_byte;
  logic [19:0] acc;
  logic nib_step;
  logic word_done_pio;
  logic ctrl_step;
  logic word_done_ctrl;
  download_pkg::mem_write_t wr;

  assign cmd_now = (hdr_count == 3'h0) ? ctrl_byte_in[7:4] : cmd;
  assign full = {hdr, ctrl_byte_in};
  assign cmd_done = ctrl_valid_in && !ctrl_start_in && state == download_pkg::ST_COMMAND
    && hdr_count == header_last(cmd_now);
  assign nib_step = have_byte && state == download_pkg::ST_PIO_DOWNLOAD && words_left != 16'h0000;
  assign word_done_pio = nib_step && nib_count == download_pkg::LAST_NIBBLE;
  assign ctrl_step = ctrl_valid_in && !ctrl_start_in && state == download_pkg::ST_MEM_WRITE
    && words_left != 16'h0000;
  assign word_done_ctrl = ctrl_step
    && word_byte == (short_mode ? download_pkg::LAST_SHORT_BYTE : download_pkg::LAST_LONG_BYTE);

  always_ff @(posedge clock_in) begin
    if (reset_in || ctrl_start_in) begin
      hdr_count <= 3'h0;
      cmd <= 4'h0;
      hdr <= 40'h0;
    end else if (ctrl_valid_in && state == download_pkg::ST_COMMAND) begin
      cmd <= cmd_now;
      hdr <= full[39:0];
      if (!cmd_done && hdr_count != 3'h7) begin
        hdr_count <= hdr_count + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= download_pkg::ST_COMMAND;
      words_left <= 16'h0000;
      write_addr <= 16'h0000;
      short_mode <= 1'b0;
      mem_second <= 1'b0;
    end else begin
      case (state)
        download_pkg::ST_COMMAND: begin
          if (cmd_done && cmd_now == download_pkg::CMD_FAST_DOWNLOAD) begin
            state <= download_pkg::ST_PIO_DOWNLOAD;
            words_left <= {4'h0, full[27:16]};
            write_addr <= full[15:0];
            mem_second <= full[download_pkg::MEM_SELECT_BIT];
          end else if (cmd_done && (cmd_now == download_pkg::CMD_MEM_WRITE_FIRST
              || cmd_now == download_pkg::CMD_MEM_WRITE_SECOND)) begin
            state <= download_pkg::ST_MEM_WRITE;
            words_left <= full[31:16];
            write_addr <= full[15:0];
            short_mode <= (full[43:40] == download_pkg::SHORT_WRITE_MODE);
            mem_second <= (cmd_now == download_pkg::CMD_MEM_WRITE_SECOND);
          end
        end
        download_pkg::ST_MEM_WRITE: begin
          if (ctrl_start_in || words_left == 16'h0000) begin
            state <= download_pkg::ST_COMMAND;
          end else if (word_done_ctrl) begin
            words_left <= words_left - 16'h0001;
            write_addr <= write_addr + 16'h0001;
          end
        end
        download_pkg::ST_PIO_DOWNLOAD: begin
          if (words_left == 16'h0000 && !have_byte) begin
            state <= download_pkg::ST_COMMAND;
          end else if (word_done_pio) begin
            words_left <= words_left - 16'h0001;
            write_addr <= write_addr + 16'h0001;
          end
        end
        default: state <= download_pkg::ST_COMMAND;
      endcase
    end
  end

  // Nibble and byte assembly; a pad nibble after the last word is simply dropped
  always_ff @(posedge clock_in) begin
    if (reset_in || state == download_pkg::ST_COMMAND) begin
      nib_count <= 3'h0;
      word_byte <= 2'h0;
      acc <= 20'h00000;
    end else if (nib_step) begin
      acc <= {acc[15:0], nib};
      nib_count <= word_done_pio ? 3'h0 : nib_count + 3'h1;
    end else if (ctrl_step) begin
      acc <= {acc[11:0], ctrl_byte_in};
      word_byte <= word_done_ctrl ? 2'h0 : word_byte + 2'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr <= '0;
    end else begin
      wr.we <= word_done_pio || word_done_ctrl;
      wr.addr <= {mem_second, write_addr[11:0]};
      if (word_done_pio) begin
        wr.data <= {acc[15:0], nib};
      end else begin
        wr.data <= {short_mode ? 4'h0 : acc[11:8], acc[7:0], ctrl_byte_in};
      end
    end
  end

  program_data_memory memory (
    .clock_in(clock_in),
    .write_in(wr),
    .read_addr_in(dsp_fetch_addr_in),
    .read_data_out(dsp_fetch_data_out)
  );

  assign download_busy_out = (state != download_pkg::ST_COMMAND);

  // ******************************************
  // Area select register, freeze and run
  // ******************************************
  logic [19:0] area_select;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      area_select <= download_pkg::AREA_SELECT_RESET;
    end else if (cmd_done && cmd_now == download_pkg::CMD_REG_WRITE && is_area_index(full[27:20])) begin
      area_select <= full[19:0];
    end
  end

  assign program_ram_area_select_out = area_select;
  assign program_area_enable_out = area_select[download_pkg::AREA_FIELD_LSB +: 4];

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      freeze_out <= 1'b0;
      run_pulse_out <= 1'b0;
      run_address_out <= 16'h0000;
    end else begin
      run_pulse_out <= cmd_done && cmd_now == download_pkg::CMD_RUN;
      if (cmd_done && cmd_now == download_pkg::CMD_RUN) begin
        freeze_out <= 1'b0;
        run_address_out <= {4'h0, full[11:0]};
      end else if (cmd_done && cmd_now == download_pkg::CMD_FREEZE) begin
        freeze_out <= 1'b1;
      end
    end
  end

  // ******************************************
  // Version words
  // ******************************************
  logic [1:0] ver_left;
  logic [15:0] ver_word;
  logic ver_ready;

  assign ver_word = (ver_left == download_pkg::VERSION_WORDS) ? VERSION.major
    : {VERSION.derivative, VERSION.letter, VERSION.digit};

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ver_left <= 2'h0;
    end else if (cmd_done && cmd_now == download_pkg::CMD_VERSION) begin
      ver_left <= download_pkg::VERSION_WORDS;
    end else if (ver_left != 2'h0 && ver_ready) begin
      ver_left <= ver_left - 2'h1;
    end
  end

  two_entry_buffer #(.WIDTH(16)) version_buffer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .in_data_in(ver_word),
    .in_valid_in(ver_left != 2'h0),
    .in_ready_out(ver_ready),
    .out_data_out(version_data_out),
    .out_valid_out(version_valid_out),
    .out_ready_in(version_ready_in)
  );

  // ******************************************
  // Checks
  // ******************************************
  fast_download_start_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (cmd_done && cmd_now == download_pkg::CMD_FAST_DOWNLOAD) |=>
    (state == download_pkg::ST_PIO_DOWNLOAD && words_left == {4'h0, $past(full[27:16])}))
    else $error("fast download did not start with the given count");
  word_address_step_a: assert property (@(posedge clock_in) disable iff (reset_in)
    word_done_pio |=> (wr.we && write_addr == $past(write_addr) + 16'h0001))
    else $error("download word not written at next address");
  nibble_order_a: assert property (@(posedge clock_in) disable iff (reset_in)
    word_done_pio |=> (wr.data[3:0] == $past(nib) && wr.data[19:4] == $past(acc[15:0])))
    else $error("download word nibbles out of order");
  count_end_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (state == download_pkg::ST_PIO_DOWNLOAD && words_left == 16'h0000 && !have_byte) |=>
    (state == download_pkg::ST_COMMAND && !wr.we))
    else $error("download went on after count reached");
  version_pair_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (cmd_done && cmd_now == download_pkg::CMD_VERSION) |=> (ver_left == 2'h2) ##[1:300] (ver_left == 2'h0))
    else $error("version query did not queue two words");
  version_major_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (cmd_done && cmd_now == download_pkg::CMD_VERSION && ver_left == 2'h0 && !version_valid_out) |=>
    ##1 (version_valid_out && version_data_out == VERSION.major))
    else $error("first version word is not the major number");
  version_second_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (ver_left == 2'h1) |-> (ver_word[15:12] == VERSION.derivative && ver_word[11:8] == VERSION.letter))
    else $error("second version word fields misplaced");
  area_write_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (cmd_done && cmd_now == download_pkg::CMD_REG_WRITE && full[27:20] == download_pkg::AREA_SELECT_INDEX) |=>
    (area_select == $past(full[19:0])))
    else $error("area select register not written");
  run_start_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (cmd_done && cmd_now == download_pkg::CMD_RUN) |=> (run_pulse_out && !freeze_out) ##1 !run_pulse_out)
    else $error("run command did not pulse once");
  mem_write_target_a: assert property (@(posedge clock_in) disable iff (reset_in)
    word_done_ctrl |=> (wr.we && wr.addr[download_pkg::MEM_SELECT_BIT] == $past(mem_second)))
    else $error("memory write went to the wrong memory");
  pio_single_a: assert property (@(posedge pio_clock_in) disable iff (link_reset)
    (pio_valid_in && pio_ready_out) |=> !pio_ready_out)
    else $error("parallel port took a second byte before ack");
endmodule

// ==== test/pio_host_model.sv ====
// Host side of the parallel download port: offers queued bytes one at a time.
// Assumes the bench fills q and the port clock keeps running.
`timescale 1ns/1ps
module pio_host_model (
  input wire logic pio_clock_in,
  input wire logic pio_ready_in,
  output logic pio_valid_out = 1'b0,
  output logic [7:0] pio_byte_out = 8'h00
);
  logic [7:0] q[$];

  // Random stalls between bytes; a released bus shows the inverse of the last byte
  always @(posedge pio_clock_in) begin
    if (pio_valid_out && pio_ready_in) begin
      pio_valid_out <= 1'b0;
      pio_byte_out <= ~pio_byte_out;
    end else if (!pio_valid_out && q.size() > 0 && $urandom_range(3) != 0) begin
      pio_valid_out <= 1'b1;
      pio_byte_out <= q.pop_front();
    end
  end
endmodule

// ==== test/program_download_version_cmds_tb.sv ====
// Self-checking bench for the download command interpreter.
// Assumes command bytes arrive already stripped of address and subaddress.
`timescale 1ns/1ps
module program_download_version_cmds_tb;
  // Arbitrary version values
  localparam download_pkg::version_t VER = '{16'h4821, 4'h3, 4'h5, 8'h19};
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic pio_clock_in = 1'b0;
  logic ctrl_start_in = 1'b0;
  logic ctrl_valid_in = 1'b0;
  logic version_ready_in = 1'b0;
  logic [7:0] ctrl_byte_in = 8'h00;
  logic [download_pkg::MEM_ADDR_WIDTH-1:0] dsp_fetch_addr_in = 13'h0000;
  logic [15:0] version_data_out;
  logic version_valid_out;
  logic pio_valid_in;
  logic [7:0] pio_byte_in;
  logic pio_ready_out;
  logic [19:0] dsp_fetch_data_out;
  logic [19:0] area_sel;
  logic [3:0] area_en;
  logic freeze_out;
  logic run_pulse_out;
  logic [15:0] run_address_out;
  logic download_busy_out;
  int n_fail = 0;
  int n_compared = 0;
  int n_runs = 0;
  logic [7:0] cmd_q[$];
  logic [15:0] exp_q[$];

  initial forever #20 clock_in = ~clock_in;
  initial begin
    #7;
    forever #16 pio_clock_in = ~pio_clock_in;
  end

  download_cmd_interpreter #(.VERSION(VER)) dut (.clock_in(clock_in), .reset_in(reset_in),
    .ctrl_start_in(ctrl_start_in), .ctrl_valid_in(ctrl_valid_in), .ctrl_byte_in(ctrl_byte_in),
    .version_data_out(version_data_out), .version_valid_out(version_valid_out),
    .version_ready_in(version_ready_in), .pio_clock_in(pio_clock_in), .pio_valid_in(pio_valid_in),
    .pio_byte_in(pio_byte_in), .pio_ready_out(pio_ready_out), .dsp_fetch_addr_in(dsp_fetch_addr_in),
    .dsp_fetch_data_out(dsp_fetch_data_out), .program_ram_area_select_out(area_sel),
    .program_area_enable_out(area_en), .freeze_out(freeze_out), .run_pulse_out(run_pulse_out),
    .run_address_out(run_address_out), .download_busy_out(download_busy_out));

  pio_host_model host (.pio_clock_in(pio_clock_in), .pio_ready_in(pio_ready_out),
    .pio_valid_out(pio_valid_in), .pio_byte_out(pio_byte_in));

  // ******************************************
  // Tasks
  // ******************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // New transaction, then the bytes of cmd_q back to back
  task send_cmd;
    @(posedge clock_in);
    ctrl_start_in <= 1'b1;
    @(posedge clock_in);
    ctrl_start_in <= 1'b0;
    foreach (cmd_q[i]) begin
      ctrl_valid_in <= 1'b1;
      ctrl_byte_in <= cmd_q[i];
      @(posedge clock_in);
    end
    ctrl_valid_in <= 1'b0;
    ctrl_byte_in <= ~ctrl_byte_in;
    repeat (2) @(posedge clock_in);
    #1;
  endtask

  task read_mem(input logic [12:0] addr, input logic [19:0] exp);
    @(posedge clock_in);
    dsp_fetch_addr_in <= addr;
    repeat (2) @(posedge clock_in);
    #1;
    check(32'(dsp_fetch_data_out), 32'(exp));
  endtask

  task download(input logic [15:0] addr, input logic [11:0] n);
    logic [19:0] words[$];
    logic [3:0] nib[$];
    words = {};
    nib = {};
    cmd_q = '{8'h60 | 8'(n[11:8]), n[7:0], addr[15:8], addr[7:0]};
    send_cmd();
    check(32'(download_busy_out), 32'h1);
    for (int i = 0; i < n; i++) words.push_back(20'($urandom));
    foreach (words[i]) for (int k = 4; k >= 0; k--) nib.push_back(words[i][4*k+:4]);
    if (n[0]) nib.push_back(4'($urandom));
    for (int j = 0; j < nib.size(); j += 2) host.q.push_back({nib[j], nib[j+1]});
    for (int i = 0; i < 4000 && download_busy_out !== 1'b0; i++) @(posedge clock_in);
    check(32'(download_busy_out), 32'h0);
    foreach (words[i]) read_mem({addr[12], addr[11:0] + 12'(i)}, words[i]);
  endtask

  // ******************************************
  // Version word scoreboard and run pulse count
  // ******************************************
  always @(posedge clock_in) begin
    version_ready_in <= 1'($urandom_range(1));
    if (run_pulse_out === 1'b1) n_runs++;
    if (version_valid_out === 1'b1 && version_ready_in === 1'b1) begin
      if (exp_q.size() == 0) check(32'(version_data_out), 32'hffffffff);
      else check(32'(version_data_out), 32'(exp_q.pop_front()));
    end
  end

  initial begin
    #500000;
    n_fail++;
    give_verdict();
  end

  // ******************************************
  // Main sequence
  // ******************************************
  initial begin
    void'($urandom(98));
    repeat (8) @(posedge clock_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    check(32'(area_sel), 32'h0);
    check({28'h0000000, area_en}, 32'h0);
    check(32'({download_busy_out, version_valid_out, freeze_out, run_address_out}), 32'h0);
    cmd_q = '{8'h00, 8'h00};
    send_cmd();
    check(32'(freeze_out), 32'h1);
    cmd_q = '{8'hb1, 8'h2f, 8'hff, 8'hff};
    send_cmd();
    check(32'(area_sel), 32'h0);
    cmd_q = '{8'hb6, 8'hb8, 8'h12, 8'h34};
    send_cmd();
    check(32'(area_sel), 32'h81234);
    check({28'h0000000, area_en}, 32'h8);
    download(16'h0800, 12'h003);
    download(16'h1200, 12'h002);
    cmd_q = '{8'he0, 8'h00, 8'h00, 8'h01, 8'h04, 8'h56, 8'h00, 8'h08, 8'h02, 8'h34};
    send_cmd();
    read_mem(13'h0456, 20'h80234);
    cmd_q = '{8'hf4, 8'h00, 8'h00, 8'h01, 8'h01, 8'h23, 8'hab, 8'hcd};
    send_cmd();
    read_mem(13'h1123, 20'h0abcd);
    cmd_q = '{8'hbe, 8'hd5, 8'h00, 8'h00};
    send_cmd();
    check(32'(area_sel), 32'h50000);
    check({28'h0000000, area_en}, 32'h5);
    for (int v = 0; v < 2; v++) begin
      exp_q.push_back(VER.major);
      exp_q.push_back({4'h3, 4'(8'h46 - 8'h41), 8'h19});
      cmd_q = '{8'h70, 8'h00};
      send_cmd();
      repeat (30) @(posedge clock_in);
      check(32'(exp_q.size()), 32'h0);
    end
    n_runs = 0;
    cmd_q = '{8'h10, 8'h0a};
    send_cmd();
    repeat (3) @(posedge clock_in);
    #1;
    check(32'(n_runs), 32'h1);
    check(32'(run_address_out), 32'h000a);
    check(32'(freeze_out), 32'h0);
    give_verdict();
  end
endmodule
